//--- src/pbim_pkg.sv
// Constants for the power button interrupt mask and sense block
package pbim_pkg;

   // ---------------------------------------------------------------
   // Bus shape
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] STAT_IDX  = 8'h24;
   localparam logic [7:0] MASK_IDX  = 8'h25;
   localparam logic [7:0] SENSE_IDX = 8'h26;
   localparam logic [7:0] DEB_IDX   = 8'h2C;

   // ---------------------------------------------------------------
   // Fields
   // ---------------------------------------------------------------
   localparam int NUM_FLAGS  = 6;
   localparam int NUM_HELD   = 5;
   localparam int PRESS_BIT  = 0;
   localparam int HELD_LSB   = 1;
   localparam int DEB_PRESS_LSB   = 0;
   localparam int DEB_RELEASE_LSB = 8;
   localparam int DEB_LEN_W  = 8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] MASK_RST        = 6'h3F;
   localparam logic [7:0] DEB_PRESS_RST   = 8'h20;
   localparam logic [7:0] DEB_RELEASE_RST = 8'h20;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ       = 20_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int HOLD_CNT_W   = 13;
   // Held thresholds in ms: 1, 2, 3, 4 and 8 s, lowest first
   localparam logic [HOLD_CNT_W*NUM_HELD-1:0] HOLD_MS_TABLE =
      {13'h1F40, 13'h0FA0, 13'h0BB8, 13'h07D0, 13'h03E8};
   localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_MAX = 13'h1FFF;

   typedef enum logic [1:0] {
      SEL_NONE  = 2'b00,
      SEL_STAT  = 2'b01,
      SEL_MASK  = 2'b10,
      SEL_OTHER = 2'b11
   } pbim_sel_t;

endpackage

//--- src/pbim_debounce.sv
// Press and release debounce for the power button
`timescale 1ns/100ps
module pbim_debounce #(
   parameter int LEN_W = 8
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Time base and settings
   input  wire logic             tick,
   input  wire logic [LEN_W-1:0] press_len,
   input  wire logic [LEN_W-1:0] release_len,
   // Button, synchronised, high while pressed
   input  wire logic             raw_pressed,
   output logic                  level
);

   logic [LEN_W-1:0] cnt_r;
   logic             level_r;
   logic [LEN_W-1:0] len;

   generate
      if (LEN_W < 1 || LEN_W > 16) begin : g_chk
         $error("pbim_debounce: LEN_W out of range");
      end
   endgenerate

   assign len   = level_r ? release_len : press_len;
   assign level = level_r;

   // Level moves only after the input disagrees for len ticks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r   <= '0;
         level_r <= 1'b0;
      end else if (raw_pressed == level_r) begin
         cnt_r <= '0;
      end else if (cnt_r >= len) begin
         cnt_r   <= '0;
         level_r <= raw_pressed;
      end else if (tick) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

endmodule // pbim_debounce

//--- src/pbim_top.sv
// Power button interrupt mask, sense and status with AXI4-Lite access
//
// How it works
// - Mask bit 0 lets a set status flag pull irq_request_n low.
// - Mask bit 1 keeps that flag from pulling irq_request_n low.
// - Mask register 0x25 bits 0..5: press, 1s, 2s, 3s, 4s, 8s; 7..6 unused.
// - Mask bits are read-write and reset to 1.
// - Sense bit 0 at 0x26 is 1 while debounced button is low.
// - Raw button passes a programmable debounce before sense and flags move.
// - Sense bit 1 goes 1 once held more than 1 s.
// - Sense bits 2..5 go 1 once held beyond 2, 3, 4, 8 s.
// - All held sense bits clear together when press sense returns to 0.
// - Sense register read-only, resets to 0, bits 7..6 unused, writes ignored.
// - A status flag clears on a read of it or a write of 1.
// - Press flag sets on every change of debounced press sense.
// - Held flags at 0x24 set when their hold threshold is passed.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module pbim_top
   import pbim_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = pbim_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // AXI4-Lite write address
   input  wire logic [pbim_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [pbim_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [pbim_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   // AXI4-Lite read data
   output logic [pbim_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Button pin, low while pushed
   input  wire logic                        power_button,
   // Other interrupt groups, high while requesting
   input  wire logic                        other_irq,
   // Interrupt request, active low
   output logic                             irq_request_n
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int TW = $clog2(TICK_CYCLES + 1);

   typedef enum logic {
      WR_COLLECT = 1'b0,
      WR_RESP    = 1'b1
   } pbim_wr_t;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } pbim_rd_t;

   pbim_wr_t                  wr_state_r;
   pbim_rd_t                  rd_state_r;
   logic                      awready_r;
   logic                      wready_r;
   logic                      arready_r;
   logic                      bvalid_r;
   logic [1:0]                bresp_r;
   logic                      rvalid_r;
   logic [1:0]                rresp_r;
   logic [DATA_W-1:0]         rdata_r;
   logic                      aw_got_r;
   logic                      w_got_r;
   logic [ADDR_W-1:0]         awaddr_r;
   logic [DATA_W-1:0]         wdata_r;
   logic [3:0]                wstrb_r;
   logic                      do_wr;
   logic                      do_rd;
   pbim_sel_t                 wr_sel;
   pbim_sel_t                 rd_sel;

   logic [NUM_FLAGS-1:0]      mask_r;
   logic [NUM_FLAGS-1:0]      flag_r;
   logic [NUM_FLAGS-1:0]      flag_nxt;
   logic [NUM_FLAGS-1:0]      flag_set;
   logic [NUM_FLAGS-1:0]      flag_clr;
   logic [NUM_FLAGS-1:0]      sense;
   logic [NUM_HELD-1:0]       held_level_r;
   logic [NUM_HELD-1:0]       held_prev_r;
   logic [DEB_LEN_W-1:0]      deb_press_r;
   logic [DEB_LEN_W-1:0]      deb_release_r;
   logic                      irq_n_r;

   logic                      btn_meta_r;
   logic                      btn_sync_r;
   logic [TW-1:0]             tick_cnt_r;
   logic                      tick_r;
   logic                      press_level;
   logic                      press_prev_r;
   logic [HOLD_CNT_W-1:0]     hold_ms_r;

   generate
      if (TICK_CYCLES < 1) begin : g_chk
         $error("pbim_top: TICK_CYCLES must be at least 1");
      end
   endgenerate

   // Register select by word index; bits 1:0 are ignored
   function automatic pbim_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
      if (addr[ADDR_W-1:2] == STAT_IDX[ADDR_W-3:0]) begin
         reg_sel = SEL_STAT;
      end else if (addr[ADDR_W-1:2] == MASK_IDX[ADDR_W-3:0]) begin
         reg_sel = SEL_MASK;
      end else if (addr[ADDR_W-1:2] == SENSE_IDX[ADDR_W-3:0]) begin
         reg_sel = SEL_OTHER;
      end else if (addr[ADDR_W-1:2] == DEB_IDX[ADDR_W-3:0]) begin
         reg_sel = SEL_OTHER;
      end else begin
         reg_sel = SEL_NONE;
      end
   endfunction

   assign wr_sel = reg_sel(awaddr_r);
   assign rd_sel = reg_sel(s_axi_araddr);
   assign do_wr  = aw_got_r && w_got_r && (wr_state_r == WR_COLLECT);
   assign do_rd  = s_axi_arvalid && arready_r;

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign irq_request_n = irq_n_r;

   // ---------------------------------------------------------------
   // Write channels: address and data taken in either order
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         aw_got_r  <= 1'b0;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_got_r  <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_got_r <= 1'b0;
      end else if (!aw_got_r && wr_state_r == WR_COLLECT) begin
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b0;
         w_got_r  <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_got_r  <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (do_wr) begin
         w_got_r <= 1'b0;
      end else if (!w_got_r && wr_state_r == WR_COLLECT) begin
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r <= WR_COLLECT;
         bvalid_r   <= 1'b0;
         bresp_r    <= RESP_OKAY;
      end else begin
         case (wr_state_r)
            WR_COLLECT: begin
               if (do_wr) begin
                  wr_state_r <= WR_RESP;
                  bvalid_r   <= 1'b1;
                  bresp_r    <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
               end
            end
            default: begin
               if (s_axi_bready) begin
                  wr_state_r <= WR_COLLECT;
                  bvalid_r   <= 1'b0;
               end
            end
         endcase
      end
   end

   // Mask and debounce settings; sense register has no write path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r        <= MASK_RST;
         deb_press_r   <= DEB_PRESS_RST;
         deb_release_r <= DEB_RELEASE_RST;
      end else if (do_wr) begin
         if (wr_sel == SEL_MASK && wstrb_r[0]) begin
            mask_r <= wdata_r[NUM_FLAGS-1:0];
         end else if (awaddr_r[ADDR_W-1:2] == DEB_IDX[ADDR_W-3:0]) begin
            if (wstrb_r[0]) begin
               deb_press_r <= wdata_r[DEB_PRESS_LSB +: DEB_LEN_W];
            end
            if (wstrb_r[1]) begin
               deb_release_r <= wdata_r[DEB_RELEASE_LSB +: DEB_LEN_W];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= RD_IDLE;
         arready_r  <= 1'b0;
         rvalid_r   <= 1'b0;
         rresp_r    <= RESP_OKAY;
         rdata_r    <= '0;
      end else begin
         case (rd_state_r)
            RD_IDLE: begin
               arready_r <= !do_rd;
               if (do_rd) begin
                  rd_state_r <= RD_DATA;
                  rvalid_r   <= 1'b1;
                  rresp_r    <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                  rdata_r    <= '0;
                  if (rd_sel == SEL_STAT) begin
                     rdata_r[NUM_FLAGS-1:0] <= flag_r;
                  end else if (rd_sel == SEL_MASK) begin
                     rdata_r[NUM_FLAGS-1:0] <= mask_r;
                  end else if (s_axi_araddr[ADDR_W-1:2] == SENSE_IDX[ADDR_W-3:0]) begin
                     rdata_r[NUM_FLAGS-1:0] <= sense;
                  end else if (rd_sel == SEL_OTHER) begin
                     rdata_r[DEB_PRESS_LSB +: DEB_LEN_W]   <= deb_press_r;
                     rdata_r[DEB_RELEASE_LSB +: DEB_LEN_W] <= deb_release_r;
                  end
               end
            end
            default: begin
               arready_r <= 1'b0;
               if (s_axi_rready) begin
                  rd_state_r <= RD_IDLE;
                  rvalid_r   <= 1'b0;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Button input: synchroniser, ms time base, debounce
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         btn_meta_r <= 1'b1;
         btn_sync_r <= 1'b1;
      end else begin
         btn_meta_r <= power_button;
         btn_sync_r <= btn_meta_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == TW'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_r     <= 1'b0;
      end
   end

   pbim_debounce #(
      .LEN_W       (DEB_LEN_W)
   ) u_debounce (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .tick        (tick_r),
      .press_len   (deb_press_r),
      .release_len (deb_release_r),
      .raw_pressed (!btn_sync_r),
      .level       (press_level)
   );

   // ---------------------------------------------------------------
   // Hold timer and held levels
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_ms_r <= '0;
      end else if (!press_level || !press_prev_r) begin
         hold_ms_r <= '0;
      end else if (tick_r && hold_ms_r != HOLD_CNT_MAX) begin
         hold_ms_r <= hold_ms_r + 1'b1;
      end
   end

   generate
      for (genvar g = 0; g < NUM_HELD; g++) begin : g_held
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               held_level_r[g] <= 1'b0;
            end else if (!press_level) begin
               held_level_r[g] <= 1'b0;
            end else if (hold_ms_r > HOLD_MS_TABLE[g*HOLD_CNT_W +: HOLD_CNT_W]) begin
               held_level_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign sense = {held_level_r, press_level};

   // ---------------------------------------------------------------
   // Status flags: hardware set beats software clear
   // ---------------------------------------------------------------
   always_comb begin
      flag_set = '0;
      flag_set[PRESS_BIT] = press_level ^ press_prev_r;
      flag_set[HELD_LSB +: NUM_HELD] = held_level_r & ~held_prev_r;
      flag_clr = '0;
      if (do_rd && rd_sel == SEL_STAT) begin
         flag_clr = '1;
      end
      if (do_wr && wr_sel == SEL_STAT && wstrb_r[0]) begin
         flag_clr = flag_clr | wdata_r[NUM_FLAGS-1:0];
      end
      flag_nxt = (flag_r & ~flag_clr) | flag_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_r       <= '0;
         press_prev_r <= 1'b0;
         held_prev_r  <= '0;
      end else begin
         flag_r       <= flag_nxt;
         press_prev_r <= press_level;
         held_prev_r  <= held_level_r;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt request: mask 1 blocks, mask 0 passes
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= !((|(flag_r & ~mask_r)) || other_irq);
      end
   end

endmodule // pbim_top

//--- test/pbim_button_model.sv
// Bouncing push-button model driving the power button pin
`timescale 1ns/100ps
module pbim_button_model #(
   parameter int BOUNCE = 3
) (
   // Clock
   input  wire logic aclk,
   // Bench command, high to hold the button pushed
   input  wire logic pushed,
   // Pin, pulled up while released
   output logic      power_button
);
   logic       last_r;
   logic [3:0] bounce_r;

   initial begin
      last_r = 1'b0;
      bounce_r = 4'h0;
      power_button = 1'b1;
   end

   // Contacts chatter for BOUNCE clocks after every change, then the pin settles to the inverse of pushed
   always @(posedge aclk) begin
      last_r <= pushed;
      if (pushed != last_r)
         bounce_r <= 4'(BOUNCE);
      else if (bounce_r != 4'h0)
         bounce_r <= bounce_r - 4'h1;
      power_button <= (bounce_r != 4'h0) ? ~power_button : ~pushed;
   end
endmodule // pbim_button_model

//--- test/pbim_checker.sv
// Concurrent checks on the ports of the power button interrupt block
`timescale 1ns/100ps
module pbim_checker
   import pbim_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write side
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read side
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Button and interrupts
   input wire logic        power_button,
   input wire logic        other_irq,
   input wire logic        irq_request_n
);
   logic [7:0] rd_addr_r;

   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_r <= s_axi_araddr;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_r_held;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   AST_RD_ANSWER: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   AST_RD_STAND: assert property (s_r_held |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped");
   AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   AST_WR_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   AST_ONE_WR: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_ONE_RD: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   AST_UNUSED_ZERO: assert property (s_axi_rvalid && (rd_addr_r == {MASK_IDX[5:0], 2'b00} ||
      rd_addr_r == {SENSE_IDX[5:0], 2'b00}) |-> s_axi_rdata[31:6] == 26'h0 && s_axi_rresp == RESP_OKAY)
      else $error("unused bits read nonzero");
   AST_OTHER_IRQ: assert property (other_irq |=> !irq_request_n)
      else $error("other group did not request");
endmodule // pbim_checker

bind pbim_top pbim_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .power_button(power_button), .other_irq(other_irq), .irq_request_n(irq_request_n));

//--- test/pbim_top_tb.sv
// Self-checking bench for the power button interrupt block
`timescale 1ns/100ps
module pbim_top_tb;
   import pbim_pkg::*;
   localparam int TK = 4;
   logic        aclk, aresetn, pushed, power_button, other_irq, irq_request_n;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [33:0] exp_q[$];
   int          fail_count, checks_done, seed;

   pbim_top #(.TICK_CYCLES(TK)) DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_button(power_button), .other_irq(other_irq), .irq_request_n(irq_request_n));
   pbim_button_model u_btn (.aclk(aclk), .pushed(pushed), .power_button(power_button));

   always #25 aclk = ~aclk;

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Bus master; handshakes seen at the falling edge, acted on at the rising
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      bit aw, w, b;
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      b = 0;
      while (!b && n < 200) begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         if (b) chk({32'h0, bresp}, {32'h0, er});
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
         n++;
      end
      if (!b) chk(34'h0, 34'h1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      bit ar, r;
      int n;
      exp_q.push_back({er, ed});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      r = 0;
      while (!r && n < 200) begin
         @(negedge aclk);
         ar = arvalid && arready;
         r = rvalid;
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
         if (r) rready <= 1'b0;
         n++;
      end
      if (!r) chk(34'h0, 34'h1);
   endtask

   // Read results against the oldest note
   always @(negedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         chk({rresp, rdata}, exp_q.pop_front());
      end
   end

   task automatic irq_is(input logic e);
      repeat (3) @(negedge aclk);
      chk({33'h0, irq_request_n}, {33'h0, e});
   endtask

   task automatic ticks(input int n);
      repeat (n * TK) @(posedge aclk);
   endtask

   // Ample margin over the 8490 ticks of button holding
   initial begin
      #3_000_000;
      fail_count++;
      summarize();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready, pushed, other_irq} = '0;
      wstrb = 4'hF;
      seed = 74;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      irq_is(1'b1);
      rd(8'h94, RESP_OKAY, 32'h3F);
      rd(8'h98, RESP_OKAY, 32'h0);
      rd(8'h90, RESP_OKAY, 32'h0);
      rd(8'hB0, RESP_OKAY, 32'h2020);
      rd(8'h40, RESP_SLVERR, 32'h0);
      wr(8'h40, 32'hFF, RESP_SLVERR);
      wr(8'h98, 32'hFF, RESP_OKAY);
      rd(8'h98, RESP_OKAY, 32'h0);
      d = $random(seed);
      wr(8'h94, d, RESP_OKAY);
      rd(8'h94, RESP_OKAY, {26'h0, d[5:0]});
      wr(8'h94, 32'h3F, RESP_OKAY);
      wr(8'hB0, 32'h0202, RESP_OKAY);
      pushed <= 1'b1;
      ticks(10);
      rd(8'h98, RESP_OKAY, 32'h01);
      rd(8'h90, RESP_OKAY, 32'h01);
      rd(8'h90, RESP_OKAY, 32'h00);
      wr(8'h94, 32'h3D, RESP_OKAY);
      ticks(480);
      rd(8'h98, RESP_OKAY, 32'h01);
      irq_is(1'b1);
      ticks(1000);
      rd(8'h98, RESP_OKAY, 32'h03);
      irq_is(1'b0);
      wr(8'h90, 32'h02, RESP_OKAY);
      irq_is(1'b1);
      ticks(7000);
      rd(8'h98, RESP_OKAY, 32'h3F);
      rd(8'h90, RESP_OKAY, 32'h3C);
      pushed <= 1'b0;
      ticks(10);
      rd(8'h98, RESP_OKAY, 32'h00);
      irq_is(1'b1);
      wr(8'h94, 32'h3C, RESP_OKAY);
      irq_is(1'b0);
      rd(8'h90, RESP_OKAY, 32'h01);
      irq_is(1'b1);
      wr(8'h94, 32'h3F, RESP_OKAY);
      pushed <= 1'b1;
      ticks(1);
      pushed <= 1'b0;
      ticks(10);
      rd(8'h98, RESP_OKAY, 32'h00);
      rd(8'h90, RESP_OKAY, 32'h00);
      other_irq <= 1'b1;
      irq_is(1'b0);
      @(posedge aclk);
      other_irq <= 1'b0;
      irq_is(1'b1);
      summarize();
   end
endmodule // pbim_top_tb
